// >>> common/irc_map.svh
// Register indices, field positions, reset values and vectors of the interrupt block
`ifndef IRC_MAP_SVH
`define IRC_MAP_SVH

// Register indices; byte address is four times the index
`define IRC_IDX_WAKE   10'h00E
`define IRC_IDX_MASK   10'h00F
`define IRC_IDX_FLAG   10'h03F
`define IRC_IDX_CAUSE  10'h040
`define IRC_IDX_EVT    10'h041
`define IRC_IDX_EVMSK  10'h042

// Source bit positions, shared by flags and mask
`define IRC_SRC_TMR    0
`define IRC_SRC_EXT    1
`define IRC_SRC_SER    2
`define IRC_SRC_CMP    3

// Wake control fields
`define IRC_WK_WUEN    0
`define IRC_WK_ROC     3
`define IRC_WK_SLEEP_CTRL_BIT    4
`define IRC_WK_WTE     5
`define IRC_WK_ODE     6
`define IRC_WAKE_RST   8'h31
`define IRC_WAKE_WMASK 8'h79
`define IRC_WAKE_SETON 8'h30

// Reset values of flags and mask
`define IRC_FLAG_RST   4'h0
`define IRC_MASK_RST   4'h0

// Cause register fields
`define IRC_CS_GIE     0
`define IRC_CS_RUN     1
`define IRC_CS_P       3
`define IRC_CS_T       4

// Sticky event bits
`define IRC_EV_HW      0
`define IRC_EV_SW      1
`define IRC_EV_WDT     2
`define IRC_EV_WAKE    3
`define IRC_EV_RST     4'h0
`define IRC_EVM_RST    4'h0

// Program vectors
`define IRC_VEC_HW     12'h001
`define IRC_VEC_SW     12'h002

`endif

// >>> common/irc_pkg.sv
// Types shared by the interrupt and reset cause block
package irc_pkg;

	// Four interrupt sources
	typedef logic [3:0] irc_src_t;

	// Sleep tracking modes
	typedef enum logic [1:0] {
		IRC_RUN,
		IRC_SLEEP1,
		IRC_SLEEP2
	} irc_mode_e;

endpackage

// >>> src/irc_cause.sv
// Reset cause, timeout and power-down flags, and sleep tracking
`timescale 1ns/1ps
`include "irc_map.svh"
module irc_cause
	import irc_pkg::*;
(
	input  wire logic clk,
	input  wire logic arst_n,
	input  wire logic watchdog_clear_op,
	input  wire logic sleep_op,
	input  wire logic watchdog_timeout,
	input  wire logic wake_pin_change,
	input  wire logic pin_reset,
	input  wire logic sleep_ctrl_fall,
	output logic      timeout_flag,
	output logic      power_down_flag,
	output logic      core_run,
	output logic      chip_reset,
	output logic      wake_event
);

	irc_mode_e mode;
	irc_mode_e next_mode;
	logic      rst_evt;

	assign rst_evt = watchdog_timeout | pin_reset;

	// Mode sequencing between run and the two sleep modes
	always_comb begin
		next_mode = mode;
		case (mode)
			IRC_RUN: begin
				if (rst_evt) begin
					next_mode = IRC_RUN;
				end else if (sleep_op) begin
					next_mode = IRC_SLEEP1;
				end else if (sleep_ctrl_fall) begin
					next_mode = IRC_SLEEP2;
				end
			end
			IRC_SLEEP1: begin
				if (rst_evt) begin
					next_mode = IRC_RUN;
				end
			end
			IRC_SLEEP2: begin
				if (rst_evt | wake_pin_change) begin
					next_mode = IRC_RUN;
				end
			end
			default: begin
				next_mode = IRC_RUN;
			end
		endcase
	end

	// Mode register and run release
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode     <= IRC_RUN;
			core_run <= 1'b1;
		end else begin
			mode     <= next_mode;
			core_run <= (next_mode == IRC_RUN);
		end
	end

	// Reset request towards core and block
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			chip_reset <= 1'b0;
			wake_event <= 1'b0;
		end else begin
			chip_reset <= rst_evt;
			wake_event <= (mode == IRC_SLEEP2) & wake_pin_change & ~rst_evt;
		end
	end

	// Timeout and power-down flags
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timeout_flag    <= 1'b1;
			power_down_flag <= 1'b1;
		end else if (watchdog_timeout) begin
			timeout_flag <= 1'b0;
			if (mode == IRC_SLEEP1) begin
				power_down_flag <= 1'b0;
			end
		end else if (watchdog_clear_op) begin
			timeout_flag    <= 1'b1;
			power_down_flag <= 1'b1;
		end else if (sleep_op) begin
			timeout_flag    <= 1'b1;
			power_down_flag <= 1'b0;
		end
	end

endmodule // irc_cause

// >>> src/irc_top.sv
// Interrupt controller: source flags, mask, global enable, vectors and APB registers
//
// Functional notes
// - Status register at 0x3F holds four source flags, compare, serial, pin, timer.
// - Mask register at 0x0F enables the four sources in the same order.
// - Enable instruction sets the global enable; disable instruction clears it.
// - Unmasked flag with global enable set fetches the next instruction from 001H.
// - Source flags set on their event regardless of mask and global enable.
// - Reading the status register returns flags ANDed with the mask.
// - Return-from-interrupt leaves the routine and sets the global enable.
// - Software interrupt instruction, when enabled, fetches from 002H.
// - Flags clear on power-on, pin or watchdog reset; kept over pin wake.
// - Mask bits clear on power-on, pin or watchdog reset; kept over pin wake.
// - Reset is entered on power-on and on watchdog time-out.
// - Timeout and power-down flags after each reset kind follow the cause table.
// - Watchdog clear sets both; sleep sets timeout, clears power-down; timeout clears timeout.
// - Execution stops when the sleep control bit falls and resumes with the next instruction on pin wake.
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "irc_map.svh"
module irc_top
	import irc_pkg::*;
#(
	parameter int PC_W = 12
) (
	input  wire logic            clk,
	input  wire logic            arst_n,
	input  wire logic            psel,
	input  wire logic            penable,
	input  wire logic            pwrite,
	input  wire logic [11:0]     paddr,
	input  wire logic [31:0]     pwdata,
	input  wire logic [3:0]      pstrb,
	output logic      [31:0]     prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  wire logic            evt_timer_wrap,
	input  wire logic            evt_serial_done,
	input  wire logic            evt_compare_match,
	input  wire logic            ext_pin_n,
	input  wire logic            pin_reset_n,
	input  wire logic            watchdog_timeout,
	input  wire logic            wake_pin_change,
	input  wire logic            irq_on_op,
	input  wire logic            irq_off_op,
	input  wire logic            irq_return_op,
	input  wire logic            soft_irq_op,
	input  wire logic            watchdog_clear_op,
	input  wire logic            sleep_op,
	input  wire logic [PC_W-1:0] return_pc,
	output logic                 vector_take,
	output logic      [PC_W-1:0] vector_addr,
	output logic                 stack_push,
	output logic      [PC_W-1:0] push_addr,
	output logic                 core_run,
	output logic                 core_reset,
	output logic      [7:0]      wake_ctrl,
	output logic                 irq
);

	// Register hit for a byte address against a word index
	function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
		reg_hit = (addr[11:2] == idx) && (addr[1:0] == 2'b00);
	endfunction

	// Any mapped register
	function automatic logic reg_mapped(input logic [11:0] addr);
		reg_mapped = reg_hit(addr, `IRC_IDX_WAKE) | reg_hit(addr, `IRC_IDX_MASK) |
			reg_hit(addr, `IRC_IDX_FLAG) | reg_hit(addr, `IRC_IDX_CAUSE) |
			reg_hit(addr, `IRC_IDX_EVT) | reg_hit(addr, `IRC_IDX_EVMSK);
	endfunction

	irc_src_t   flags;
	irc_src_t   next_flags;
	irc_src_t   mask;
	irc_src_t   src_evt;
	logic       gie;
	logic [7:0] next_wake;
	logic       sleep_ctrl_fall;
	logic [3:0] evt_stat;
	logic [3:0] next_evt_stat;
	logic [3:0] evt_mask;
	logic [3:0] next_evt_mask;
	logic [3:0] evt_new;
	logic [2:0] ext_sync;
	logic [1:0] rst_sync;
	logic       ext_fall;
	logic       chip_reset;
	logic       wake_event;
	logic       timeout_flag;
	logic       power_down_flag;
	logic       setup_ph;
	logic       access_ph;
	logic       wr_ok;
	logic       rd_clear;
	logic       pending;
	logic       hw_take;
	logic       sw_take;
	logic [31:0] rd_mux;
	logic [7:0]  cause_val;
	logic        flag_wr;

	// Flag reset value, applied bit by bit
	localparam irc_src_t FLAG_RST = `IRC_FLAG_RST;

	// Pin synchronisers: two stages, the third only for edge detection
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ext_sync <= 3'h7;
			rst_sync <= 2'h3;
		end else begin
			ext_sync <= {ext_sync[1:0], ext_pin_n};
			rst_sync <= {rst_sync[0], pin_reset_n};
		end
	end

	// Falling edge of the active-low external request
	assign ext_fall = ext_sync[2] & ~ext_sync[1];

	// Reset cause and sleep tracking
	irc_cause u_cause (
		.clk               (clk),
		.arst_n            (arst_n),
		.watchdog_clear_op (watchdog_clear_op),
		.sleep_op          (sleep_op),
		.watchdog_timeout  (watchdog_timeout),
		.wake_pin_change   (wake_pin_change),
		.pin_reset         (~rst_sync[1]),
		.sleep_ctrl_fall   (sleep_ctrl_fall),
		.timeout_flag      (timeout_flag),
		.power_down_flag   (power_down_flag),
		.core_run          (core_run),
		.chip_reset        (chip_reset),
		.wake_event        (wake_event)
	);

	assign core_reset = chip_reset;

	// APB phase decode; registers answer in the first access cycle
	assign setup_ph  = psel & ~penable;
	assign access_ph = psel & penable & pready;
	assign wr_ok     = access_ph & pwrite & ~pslverr & pstrb[0];
	assign rd_clear  = setup_ph & ~pwrite & reg_hit(paddr, `IRC_IDX_EVT); // Clear as data is latched

	// Source events gathered in flag order
	always_comb begin
		src_evt = 4'h0;
		src_evt[`IRC_SRC_TMR] = evt_timer_wrap;
		src_evt[`IRC_SRC_EXT] = ext_fall;
		src_evt[`IRC_SRC_SER] = evt_serial_done;
		src_evt[`IRC_SRC_CMP] = evt_compare_match;
	end

	// Flag write strobe from the register bus
	assign flag_wr = wr_ok & reg_hit(paddr, `IRC_IDX_FLAG);

	// Per-source flag: software write, then a hardware set in the same cycle wins
	for (genvar s = 0; s < 4; s++) begin : g_flag
		// Next value of this flag
		always_comb begin
			next_flags[s] = flags[s];
			if (flag_wr) begin
				next_flags[s] = pwdata[s];
			end
			next_flags[s] = next_flags[s] | src_evt[s];
		end

		// Flag bit, cleared by any chip reset but not by a pin wake
		always_ff @(posedge clk or negedge arst_n) begin
			if (!arst_n) begin
				flags[s] <= FLAG_RST[s];
			end else if (chip_reset) begin
				flags[s] <= FLAG_RST[s];
			end else begin
				flags[s] <= next_flags[s];
			end
		end
	end

	// Mask register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mask <= `IRC_MASK_RST;
		end else if (chip_reset) begin
			mask <= `IRC_MASK_RST;
		end else if (wr_ok && reg_hit(paddr, `IRC_IDX_MASK)) begin
			mask <= pwdata[3:0];
		end
	end

	// Wake control: write, then pin wake forces its fixed bits high
	always_comb begin
		next_wake = wake_ctrl;
		if (wr_ok && reg_hit(paddr, `IRC_IDX_WAKE)) begin
			next_wake = pwdata[7:0] & `IRC_WAKE_WMASK;
		end
		if (wake_event) begin
			next_wake = next_wake | `IRC_WAKE_SETON;
		end
	end

	// Wake control register and sleep bit fall detect
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wake_ctrl       <= `IRC_WAKE_RST;
			sleep_ctrl_fall <= 1'b0;
		end else if (chip_reset) begin
			wake_ctrl       <= `IRC_WAKE_RST;
			sleep_ctrl_fall <= 1'b0;
		end else begin
			wake_ctrl       <= next_wake;
			sleep_ctrl_fall <= wake_ctrl[`IRC_WK_SLEEP_CTRL_BIT] & ~next_wake[`IRC_WK_SLEEP_CTRL_BIT];
		end
	end

	// Vector arbitration; hardware request wins over a software one
	assign pending = |(flags & mask);
	assign hw_take = gie & pending & core_run & ~chip_reset;
	assign sw_take = gie & soft_irq_op & ~hw_take & core_run & ~chip_reset;

	// Global enable
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			gie <= 1'b0;
		end else if (chip_reset) begin
			gie <= 1'b0;
		end else if (hw_take | sw_take) begin
			gie <= 1'b0;
		end else if (irq_on_op | irq_return_op) begin
			gie <= 1'b1;
		end else if (irq_off_op) begin
			gie <= 1'b0;
		end
	end

	// Vector towards the sequencer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			vector_take <= 1'b0;
			vector_addr <= PC_W'(`IRC_VEC_HW);
		end else begin
			vector_take <= hw_take | sw_take;
			if (hw_take) begin
				vector_addr <= PC_W'(`IRC_VEC_HW);
			end else if (sw_take) begin
				vector_addr <= PC_W'(`IRC_VEC_SW);
			end
		end
	end

	// Return address push, in the same cycle as the vector
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			stack_push <= 1'b0;
			push_addr  <= '0;
		end else begin
			stack_push <= hw_take | sw_take;
			if (hw_take | sw_take) begin
				push_addr <= return_pc;
			end
		end
	end

	// Block events for the sticky status register
	always_comb begin
		evt_new = 4'h0;
		evt_new[`IRC_EV_HW]   = hw_take;
		evt_new[`IRC_EV_SW]   = sw_take;
		evt_new[`IRC_EV_WDT]  = watchdog_timeout;
		evt_new[`IRC_EV_WAKE] = wake_event;
	end

	// Sticky status: read clears, a new event in the same cycle survives
	always_comb begin
		next_evt_stat = rd_clear ? 4'h0 : evt_stat;
		next_evt_stat = next_evt_stat | evt_new;
	end

	// Sticky mask written from the register bus
	always_comb begin
		next_evt_mask = evt_mask;
		if (wr_ok && reg_hit(paddr, `IRC_IDX_EVMSK)) begin
			next_evt_mask = pwdata[3:0];
		end
	end

	// Sticky status and its mask
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			evt_stat <= `IRC_EV_RST;
			evt_mask <= `IRC_EVM_RST;
		end else begin
			evt_stat <= next_evt_stat;
			evt_mask <= next_evt_mask;
		end
	end

	// Level interrupt, high while an unmasked sticky bit is set
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_evt_stat & next_evt_mask);
		end
	end

	// Cause register contents
	always_comb begin
		cause_val = 8'h00;
		cause_val[`IRC_CS_GIE] = gie;
		cause_val[`IRC_CS_RUN] = core_run;
		cause_val[`IRC_CS_P]   = power_down_flag;
		cause_val[`IRC_CS_T]   = timeout_flag;
	end

	// Read data selection
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (reg_hit(paddr, `IRC_IDX_WAKE)) begin
			rd_mux = {24'h00_0000, wake_ctrl};
		end else if (reg_hit(paddr, `IRC_IDX_MASK)) begin
			rd_mux = {28'h000_0000, mask};
		end else if (reg_hit(paddr, `IRC_IDX_FLAG)) begin
			rd_mux = {28'h000_0000, flags & mask};
		end else if (reg_hit(paddr, `IRC_IDX_CAUSE)) begin
			rd_mux = {24'h00_0000, cause_val};
		end else if (reg_hit(paddr, `IRC_IDX_EVT)) begin
			rd_mux = {28'h000_0000, evt_stat};
		end else if (reg_hit(paddr, `IRC_IDX_EVMSK)) begin
			rd_mux = {28'h000_0000, evt_mask};
		end
	end

	// APB answer: ready, data and error prepared in the setup cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~reg_mapped(paddr);
			if (setup_ph && !pwrite) begin
				prdata <= rd_mux;
			end
		end
	end

endmodule // irc_top

// >>> test/irc_seq_model.sv
// Core sequencer model that issues one-cycle instruction strobes
`timescale 1ns/1ps
module irc_seq_model (
	input  wire logic        clk,
	output logic      [5:0]  op,
	output logic      [11:0] pc
);
	// Idle strobes and return address at time zero
	initial begin
		op = 6'h00;
		pc = 12'h000;
	end

	// Strobe a, then optionally strobe b in the very next cycle
	task automatic fire(input int a, input int b);
		op <= 6'(1 << a);
		pc <= 12'($urandom);
		@(posedge clk);
		op <= (b < 0) ? 6'h00 : 6'(1 << b);
		if (b >= 0) begin
			@(posedge clk);
			op <= 6'h00;
		end
	endtask
endmodule // irc_seq_model

// >>> test/irc_top_chk.sv
// Assertions on vectors, global enable, watchdog and sleep of the interrupt block
`timescale 1ns/1ps
module irc_top_chk #(
	parameter int PC_W = 12
) (
	input wire logic            clk,
	input wire logic            arst_n,
	input wire logic            irq_on_op,
	input wire logic            irq_off_op,
	input wire logic            irq_return_op,
	input wire logic            soft_irq_op,
	input wire logic            sleep_op,
	input wire logic            watchdog_timeout,
	input wire logic [PC_W-1:0] return_pc,
	input wire logic            vector_take,
	input wire logic [PC_W-1:0] vector_addr,
	input wire logic            stack_push,
	input wire logic [PC_W-1:0] push_addr,
	input wire logic            core_run,
	input wire logic            core_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// Enable raised with no reset or disable in the way
	sequence gie_up;
		(irq_on_op || irq_return_op) && !irq_off_op && !core_reset && !watchdog_timeout;
	endsequence
	// Software request with nothing else in flight
	sequence soft_req;
		soft_irq_op && !irq_off_op && !vector_take && !core_reset && !watchdog_timeout && core_run;
	endsequence
	// Disable followed by a quiet cycle
	sequence gie_down;
		irq_off_op && !irq_on_op && !irq_return_op ##1 !irq_on_op && !irq_return_op;
	endsequence

	take_push_a: assert property (vector_take |-> stack_push)
		else $error("take without push");
	push_addr_a: assert property (vector_take |-> push_addr == $past(return_pc))
		else $error("wrong pushed address");
	no_retake_a: assert property (vector_take |=> !vector_take)
		else $error("take while enable cleared");
	vec_addr_a: assert property (vector_take |-> vector_addr inside {12'h001, 12'h002})
		else $error("bad vector address");
	vec_hold_a: assert property (!vector_take |-> $stable(vector_addr))
		else $error("vector moved without take");
	gie_off_a: assert property (gie_down |=> !vector_take)
		else $error("take after disable");
	sw_take_a: assert property (gie_up ##1 soft_req |=> vector_take)
		else $error("soft request not taken");
	wdt_reset_a: assert property (watchdog_timeout |=> core_reset)
		else $error("no reset on timeout");
	sleep_stop_a: assert property (sleep_op && !watchdog_timeout && !core_reset |=> !core_run)
		else $error("core still runs after sleep");
endmodule // irc_top_chk

bind irc_top irc_top_chk #(.PC_W(PC_W)) u_chk (
	.clk(clk), .arst_n(arst_n), .irq_on_op(irq_on_op), .irq_off_op(irq_off_op),
	.irq_return_op(irq_return_op), .soft_irq_op(soft_irq_op), .sleep_op(sleep_op),
	.watchdog_timeout(watchdog_timeout), .return_pc(return_pc),
	.vector_take(vector_take), .vector_addr(vector_addr), .stack_push(stack_push),
	.push_addr(push_addr), .core_run(core_run), .core_reset(core_reset)
);

// >>> test/tb.sv
// Self-checking bench for the interrupt and reset cause block
`timescale 1ns/1ps
`include "irc_map.svh"
module tb;
	logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        ext_n = 1'b1, pin_n = 1'b1, pready, perr, vtake, push, run, creset, irq, e;
	logic [11:0] paddr = 12'h000, pc, vaddr, pushed;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [7:0]  wctl;
	logic [5:0]  op;
	logic [4:0]  sig = 5'h00;
	int          error_cnt = 0, cmp_count = 0, m_flag = 0, m_mask;

	// Core clock
	always #2 clk = ~clk;

	irc_top dut (
		.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(perr), .evt_timer_wrap(sig[0]), .evt_serial_done(sig[1]),
		.evt_compare_match(sig[2]), .ext_pin_n(ext_n), .pin_reset_n(pin_n),
		.watchdog_timeout(sig[3]), .wake_pin_change(sig[4]), .irq_on_op(op[0]),
		.irq_off_op(op[1]), .irq_return_op(op[2]), .soft_irq_op(op[3]),
		.watchdog_clear_op(op[4]), .sleep_op(op[5]), .return_pc(pc), .vector_take(vtake),
		.vector_addr(vaddr), .stack_push(push), .push_addr(pushed), .core_run(run),
		.core_reset(creset), .wake_ctrl(wctl), .irq(irq)
	);
	irc_seq_model core (.clk(clk), .op(op), .pc(pc));

	// Count a comparison and report a difference
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
		cmp_count++;
		if (s !== x) begin
			error_cnt++;
			$display("MISMATCH %s expected %0h seen %0h", n, x, s);
		end
	endtask

	// Verdict and end of run
	task automatic conclude();
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// One APB transfer, released after the completing edge
	task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {i, 2'b00};
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		r = prdata;
		e = perr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [9:0] i, input int d);
		apb(1'b1, i, d);
		chk("write error", 0, e);
	endtask

	task automatic rd(input logic [9:0] i, input int x);
		apb(1'b0, i, 0);
		chk($sformatf("reg %0h", i), x, r);
	endtask

	// One-cycle event pulse, then time for the flag to land
	task automatic pulse(input int k);
		sig[k] <= 1'b1;
		@(posedge clk);
		sig[k] <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// Raise the source of flag bit k; bit 1 is the external pin
	task automatic src(input int k);
		if (k == 1) begin
			ext_n <= 1'b0;
			repeat (5) @(posedge clk);
			ext_n <= 1'b1;
			repeat (2) @(posedge clk);
		end else begin
			pulse(k == 0 ? 0 : k - 1);
		end
	endtask

	// Look for a vector in a short window and check its contents
	task automatic take(input logic x, input logic [11:0] a);
		logic f;
		f = 1'b0;
		repeat (6) begin
			@(negedge clk);
			if (vtake === 1'b1 && !f) begin
				f = 1'b1;
				chk("vector", a, vaddr);
				chk("pushed", pc, pushed);
			end
		end
		chk("take", x, f);
		@(posedge clk);
	endtask

	// Hang guard
	initial begin
		#40000;
		error_cnt++;
		conclude();
	end

	initial begin
		void'($urandom(32'h4f70e0c8));
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(`IRC_IDX_WAKE, `IRC_WAKE_RST);
		rd(`IRC_IDX_MASK, 0);
		rd(`IRC_IDX_FLAG, 0);
		rd(`IRC_IDX_CAUSE, 32'h1A);
		apb(1'b0, 10'h03E, 0);
		chk("unmapped", 1, e);
		m_mask = ($urandom % 15) + 1;
		wr(`IRC_IDX_MASK, m_mask);
		rd(`IRC_IDX_MASK, m_mask);
		// Each source sets its own bit; reads show flags under the mask
		for (int k = 0; k < 4; k++) begin
			src(k);
			m_flag |= 1 << k;
			rd(`IRC_IDX_FLAG, m_flag & m_mask);
		end
		wr(`IRC_IDX_MASK, 15);
		rd(`IRC_IDX_FLAG, m_flag);
		wr(`IRC_IDX_EVMSK, 3);
		core.fire(0, -1);
		take(1'b1, `IRC_VEC_HW);
		core.fire(2, -1);
		take(1'b1, `IRC_VEC_HW);
		wr(`IRC_IDX_FLAG, 0);
		core.fire(2, 3);
		take(1'b1, `IRC_VEC_SW);
		chk("irq", 1, irq);
		rd(`IRC_IDX_EVT, 3);
		core.fire(1, 3);
		take(1'b0, 12'h000);
		chk("irq", 0, irq);
		// Watchdog while running, its interrupt masked off
		wr(`IRC_IDX_EVMSK, 0);
		pulse(3);
		chk("irq", 0, irq);
		rd(`IRC_IDX_EVT, 4);
		rd(`IRC_IDX_MASK, 0);
		wr(`IRC_IDX_MASK, 15);
		rd(`IRC_IDX_FLAG, 0);
		rd(`IRC_IDX_CAUSE, 32'h0A);
		core.fire(5, -1);
		rd(`IRC_IDX_CAUSE, 32'h10);
		pulse(3);
		rd(`IRC_IDX_CAUSE, 32'h02);
		core.fire(4, -1);
		rd(`IRC_IDX_CAUSE, 32'h1A);
		// Second sleep mode entered by the control bit falling, left by pin wake
		wr(`IRC_IDX_MASK, 15);
		src(3);
		wr(`IRC_IDX_WAKE, 32'h21);
		repeat (2) @(posedge clk);
		rd(`IRC_IDX_CAUSE, 32'h18);
		pulse(4);
		rd(`IRC_IDX_CAUSE, 32'h1A);
		chk("wake_ctrl", 32'h31, wctl);
		rd(`IRC_IDX_FLAG, 8);
		rd(`IRC_IDX_MASK, 15);
		// Pin reset clears flags and mask, keeps timeout and power-down
		pin_n <= 1'b0;
		repeat (4) @(posedge clk);
		pin_n <= 1'b1;
		repeat (4) @(posedge clk);
		rd(`IRC_IDX_MASK, 0);
		wr(`IRC_IDX_MASK, 15);
		rd(`IRC_IDX_FLAG, 0);
		rd(`IRC_IDX_CAUSE, 32'h1A);
		conclude();
	end
endmodule // tb
